// File: hw/wor_irq_ctrl.sv
// Wired-OR interrupt enable block with APB register access, ports A/B/C and event interrupts.
// Assumes pins are asynchronous, the CAN asleep level comes from logic on clk, reset is synchronous.
`timescale 1ns/1ps
module wor_irq_ctrl #(
    parameter bit WIRED_OR_MASK_OPTION = 1'b1
) (
    input wire logic clk,                                               // 50 MHz clock
    input wire logic rst,                                               // Synchronous reset, active high
    input wire logic psel,                                              // APB select
    input wire logic penable,                                           // APB access phase
    input wire logic pwrite,                                            // APB write
    input wire logic [wor_pkg::ADDR_W-1:0] paddr,                       // APB byte address
    input wire logic [wor_pkg::DATA_W-1:0] pwdata,                      // APB write data
    output logic [wor_pkg::DATA_W-1:0] prdata,                          // APB read data
    output logic pready,                                                // APB ready
    output logic pslverr,                                               // APB error on unmapped address
    input wire logic [wor_pkg::PORT_N*wor_pkg::PORT_W-1:0] portIn,      // Port pin levels
    output logic [wor_pkg::PORT_N*wor_pkg::PORT_W-1:0] portOut,         // Port pin drive values
    output logic [wor_pkg::PORT_N*wor_pkg::PORT_W-1:0] portOe,          // Port pin output enables
    input wire logic wired_or_irq_pin,                                  // Dedicated wired-OR pin
    input wire logic canAsleep,                                         // CAN controller sleep level
    output logic wiredOrIrq,                                            // Wired-OR interrupt request
    output logic extClockOption,                                        // Clock output option bit
    output logic [2:0] eeControl,                                       // Erase, latch, pump bits
    output logic irq                                                    // Level interrupt
);
    import wor_pkg::*;

    localparam int PINS_W = PORT_N * PORT_W;

    logic [PINS_W-1:0] pinSync;
    logic dedSync;
    logic [PORT_N-1:0][PORT_W-1:0] dataReg, next_dataReg;
    logic [PORT_N-1:0][PORT_W-1:0] dirReg, next_dirReg;
    wor_ctrl_t ctrl, next_ctrl;
    logic [IRQ_W-1:0] status, next_status;
    logic [IRQ_W-1:0] mask, next_mask;
    logic woReq, next_woReq;
    logic canPrev;
    logic irqLevel, next_irqLevel;
    wor_apb_rsp_t rsp, next_rsp;
    logic [PORT_W-1:0] bIn;
    logic [PORT_W-1:0] bCond;
    logic [IRQ_W-1:0] events;
    logic [1:0] portIdx;
    logic setup;
    logic [PORT_N-1:0][PORT_W-1:0] pinWord;

    wor_sync #(.WIDTH(PINS_W + 1)) u_sync (
        .clk(clk),
        .rst(rst),
        .async({wired_or_irq_pin, portIn}),
        .synced({dedSync, pinSync})
    );

    assign pinWord = pinSync;
    assign bIn = pinWord[PORT_B];
    // Pins driven as outputs are excluded from the request
    assign bCond = bIn & ~dirReg[PORT_B];
    // Dedicated pin is high-level sensitive, port B inputs are ORed in, enable gates all
    assign next_woReq = ctrl.irqEnable & (dedSync | (|bCond));

    // Events: rising request, CAN entering sleep, CAN waking
    assign events[EV_WIRED_OR] = next_woReq & ~woReq;
    assign events[EV_CAN_SLEEP] = canAsleep & ~canPrev;
    assign events[EV_CAN_WAKE] = ~canAsleep & canPrev;

    assign setup = psel & ~penable;
    assign portIdx = paddr[3:2];

    // Register writes, status updates and the read mux
    always_comb begin
        next_dataReg = dataReg;
        next_dirReg = dirReg;
        next_ctrl = ctrl;
        next_mask = mask;
        next_status = status;
        next_rsp = '0;

        // Flag mirrors the controller state
        next_ctrl.canAsleep = canAsleep;

        if (setup) begin
            next_rsp.pready = 1'b1;
            if (paddr[1:0] != 2'b00) begin
                next_rsp.pslverr = 1'b1;
            end else if (paddr == ADDR_CTRL) begin
                next_rsp.prdata[BIT_IRQ_ENABLE] = ctrl.irqEnable;
                next_rsp.prdata[BIT_CAN_ASLEEP] = ctrl.canAsleep;
                next_rsp.prdata[BIT_EXT_CLOCK] = ctrl.extClock;
                next_rsp.prdata[BIT_EE_ERASE] = ctrl.eeErase;
                next_rsp.prdata[BIT_EE_LATCH] = ctrl.eeLatch;
                next_rsp.prdata[BIT_EE_PUMP] = ctrl.eePump;
            end else if (paddr >= ADDR_DATA_BASE && paddr < ADDR_DATA_BASE + 8'h0C) begin
                // Inputs read the pin, outputs read back the latch
                next_rsp.prdata[PORT_W-1:0] = (pinWord[portIdx] & ~dirReg[portIdx])
                                            | (dataReg[portIdx] & dirReg[portIdx]);
            end else if (paddr >= ADDR_DIR_BASE && paddr < ADDR_DIR_BASE + 8'h0C) begin
                next_rsp.prdata[PORT_W-1:0] = dirReg[portIdx];
            end else if (paddr == ADDR_IRQ_STATUS) begin
                next_rsp.prdata[IRQ_W-1:0] = status;
            end else if (paddr == ADDR_IRQ_MASK) begin
                next_rsp.prdata[IRQ_W-1:0] = mask;
            end else if (paddr == ADDR_PIN_STATE) begin
                next_rsp.prdata[PINS_W-1:0] = pinSync;
                next_rsp.prdata[PINS_W] = dedSync;
            end else begin
                next_rsp.pslverr = 1'b1;
            end
        end

        // Writes take effect at the access-phase edge, which the slave completes in one cycle
        if (psel && penable && pwrite && pready && !pslverr) begin
            if (paddr == ADDR_CTRL) begin
                // Enable can only stick when the mask option is fitted
                next_ctrl.irqEnable = WIRED_OR_MASK_OPTION & pwdata[BIT_IRQ_ENABLE];
                next_ctrl.extClock = pwdata[BIT_EXT_CLOCK];
                next_ctrl.eeLatch = pwdata[BIT_EE_LATCH];
                // Erase and pump bits cannot stand while the latch is clear
                next_ctrl.eeErase = pwdata[BIT_EE_LATCH] & pwdata[BIT_EE_ERASE];
                next_ctrl.eePump = pwdata[BIT_EE_LATCH] & pwdata[BIT_EE_PUMP];
            end else if (paddr >= ADDR_DATA_BASE && paddr < ADDR_DATA_BASE + 8'h0C) begin
                next_dataReg[portIdx] = pwdata[PORT_W-1:0];
            end else if (paddr >= ADDR_DIR_BASE && paddr < ADDR_DIR_BASE + 8'h0C) begin
                next_dirReg[portIdx] = pwdata[PORT_W-1:0];
            end else if (paddr == ADDR_IRQ_STATUS) begin
                next_status = status & ~pwdata[IRQ_W-1:0];
            end else if (paddr == ADDR_IRQ_MASK) begin
                next_mask = pwdata[IRQ_W-1:0];
            end
        end

        // A new event beats a clear in the same cycle
        next_status = next_status | events;
        next_irqLevel = |(next_status & next_mask);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            dataReg <= '{default: DATA_RESET};
            dirReg <= '{default: DIR_RESET};
            ctrl <= CTRL_FIELDS_RESET;
            status <= IRQ_RESET;
            mask <= IRQ_RESET;
            woReq <= 1'b0;
            canPrev <= 1'b0;
            irqLevel <= 1'b0;
            rsp <= '0;
        end else begin
            dataReg <= next_dataReg;
            dirReg <= next_dirReg;
            ctrl <= next_ctrl;
            status <= next_status;
            mask <= next_mask;
            woReq <= next_woReq;
            canPrev <= canAsleep;
            irqLevel <= next_irqLevel;
            rsp <= next_rsp;
        end
    end

    // Output stage: everything below is a plain flop copy
    always_ff @(posedge clk) begin
        if (rst) begin
            portOut <= '0;
            portOe <= '0;
            wiredOrIrq <= 1'b0;
            extClockOption <= 1'b0;
            eeControl <= 3'h0;
            irq <= 1'b0;
        end else begin
            portOut <= next_dataReg;
            portOe <= next_dirReg;
            wiredOrIrq <= next_woReq;
            extClockOption <= next_ctrl.extClock;
            eeControl <= {next_ctrl.eeErase, next_ctrl.eeLatch, next_ctrl.eePump};
            irq <= next_irqLevel;
        end
    end

    assign prdata = rsp.prdata;
    assign pready = rsp.pready;
    assign pslverr = rsp.pslverr;
endmodule : wor_irq_ctrl

// File: hw/wor_pkg.sv
// Constants, field layouts and carrier types for the wired-OR interrupt enable block.
// Assumes a 32-bit APB register bus with byte addresses and a single 50 MHz clock.
package wor_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int PORT_W = 8;
    localparam int PORT_N = 3;

    // Printed offset of the control register is an index; byte address is four times it
    localparam logic [ADDR_W-1:0] CTRL_INDEX = 8'h07;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h1C;
    localparam logic [ADDR_W-1:0] ADDR_DATA_BASE = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_DIR_BASE = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 8'h20;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h24;
    localparam logic [ADDR_W-1:0] ADDR_PIN_STATE = 8'h28;

    localparam int PORT_A = 0;
    localparam int PORT_B = 1;
    localparam int PORT_C = 2;

    // Control register field positions
    localparam int BIT_IRQ_ENABLE = 7;
    localparam int BIT_CAN_ASLEEP = 6;
    localparam int BIT_EXT_CLOCK = 3;
    localparam int BIT_EE_ERASE = 2;
    localparam int BIT_EE_LATCH = 1;
    localparam int BIT_EE_PUMP = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [PORT_W-1:0] DIR_RESET = 8'h00;
    localparam logic [PORT_W-1:0] DATA_RESET = 8'h00;

    // Interrupt status / mask bit positions
    localparam int IRQ_W = 3;
    localparam int EV_WIRED_OR = 0;
    localparam int EV_CAN_SLEEP = 1;
    localparam int EV_CAN_WAKE = 2;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

    typedef struct packed {
        logic irqEnable;
        logic canAsleep;
        logic extClock;
        logic eeErase;
        logic eeLatch;
        logic eePump;
    } wor_ctrl_t;

    localparam wor_ctrl_t CTRL_FIELDS_RESET = '{default: 1'b0};

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [DATA_W-1:0] prdata;
    } wor_apb_rsp_t;
endpackage : wor_pkg

// File: hw/wor_sync.sv
// Two-flop synchroniser for a bus of asynchronous pin levels.
// Assumes inputs may change at any time relative to clk.
`timescale 1ns/1ps
module wor_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,                 // System clock
    input wire logic rst,                 // Synchronous reset, active high
    input wire logic [WIDTH-1:0] async,   // Asynchronous levels
    output logic [WIDTH-1:0] synced       // Levels in the clk domain
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta <= '0;
            synced <= '0;
        end else begin
            meta <= async;
            synced <= meta;
        end
    end
endmodule : wor_sync

// File: test/wor_ext_dev.sv
// External devices on port pins and the dedicated wired-OR line.
// Assumes the bench sets the wanted levels just after a clock edge.
`timescale 1ns/1ps
module wor_ext_dev (
    input wire logic [wor_pkg::PORT_N*wor_pkg::PORT_W-1:0] drive, // Levels wanted by devices
    input wire logic pinReq, // Device pulls the dedicated line high
    input wire logic [wor_pkg::PORT_N*wor_pkg::PORT_W-1:0] portOut, // Chip drive values
    input wire logic [wor_pkg::PORT_N*wor_pkg::PORT_W-1:0] portOe, // Chip drive enables
    output logic [wor_pkg::PORT_N*wor_pkg::PORT_W-1:0] portIn, // Resolved pin levels
    output logic wired_or_irq_pin // Dedicated line level
);
    // Pins the chip drives show its value; the rest show the devices
    always_comb begin
        portIn = (portOe & portOut) | (~portOe & drive);
        wired_or_irq_pin = pinReq;
    end
endmodule : wor_ext_dev

// File: test/wor_irq_ctrl_sva.sv
// Port checker for the wired-OR interrupt block.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
module wor_irq_ctrl_sva #(
    parameter bit WIRED_OR_MASK_OPTION = 1'b1
) (
    input wire logic clk, // Clock
    input wire logic rst, // Reset
    input wire logic psel, // Select
    input wire logic penable, // Access
    input wire logic pwrite, // Write
    input wire logic [wor_pkg::ADDR_W-1:0] paddr, // Address
    input wire logic [wor_pkg::DATA_W-1:0] prdata, // Read data
    input wire logic pready, // Ready
    input wire logic pslverr, // Error
    input wire logic [wor_pkg::PORT_N*wor_pkg::PORT_W-1:0] portIn, // Pins
    input wire logic [wor_pkg::PORT_N*wor_pkg::PORT_W-1:0] portOe, // Drive enables
    input wire logic wired_or_irq_pin, // Dedicated pin
    input wire logic wiredOrIrq, // Request
    input wire logic irq // Interrupt
);
    import wor_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_setup;
        psel && !penable;
    endsequence
    a_reset_state: assert property (disable iff (1'b0) rst |=> portOe == '0 && !wiredOrIrq && !irq)
        else $error("outputs not cleared by reset");
    a_ready_setup: assert property (s_setup |=> pready)
        else $error("no ready after setup");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_rdata_idle: assert property (!pready |-> prdata == '0)
        else $error("read data outside access");
    a_err_ready: assert property (pslverr |-> pready && paddr != ADDR_CTRL)
        else $error("error on mapped control");
    a_ctrl_zeros: assert property (pready && !pwrite && paddr == ADDR_CTRL |-> prdata[31:8] == '0 && prdata[5:4] == '0)
        else $error("control reserved bits set");
    a_req_cause: assert property (wiredOrIrq |-> $past(wired_or_irq_pin, 3) || |$past(portIn[15:8], 3))
        else $error("request without a high line");
    a_option_off: assert property (!WIRED_OR_MASK_OPTION |-> !wiredOrIrq)
        else $error("request without mask option");
    a_dir_write: assert property ($changed(portOe) |-> $past(psel && penable && pwrite) || $past(rst))
        else $error("direction changed without write");
endmodule : wor_irq_ctrl_sva

bind wor_irq_ctrl wor_irq_ctrl_sva #(.WIRED_OR_MASK_OPTION(WIRED_OR_MASK_OPTION)) i_wor_irq_ctrl_sva (.clk, .rst,
    .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .portIn, .portOe, .wired_or_irq_pin, .wiredOrIrq,
    .irq);

// File: test/wor_irq_ctrl_tb_top.sv
// Self-checking bench with a reference model of the wired-OR request.
// Assumes the package, the device model and the checker are compiled first.
`timescale 1ns/1ps
module wor_irq_ctrl_tb_top;
    import wor_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pinReq = 1'b0, canAsleep = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, prdataOff, rd, rdOff;
    logic pready, pslverr, wiredOrIrq, irq, reqOff, wired_or_irq_pin, errS;
    logic [23:0] drive = 24'h0, portIn, portOut, portOe;
    int err_count = 0, n_checks = 0;
    int en, dir, ext, cs, expv;
    always #10 clk = ~clk;
    wor_ext_dev i_wor_ext_dev (.drive, .pinReq, .portOut, .portOe, .portIn, .wired_or_irq_pin);
    wor_irq_ctrl i_wor_irq_ctrl (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .portIn, .portOut, .portOe, .wired_or_irq_pin, .canAsleep, .wiredOrIrq, .extClockOption(), .eeControl(), .irq);
    wor_irq_ctrl #(.WIRED_OR_MASK_OPTION(1'b0)) i_wor_irq_ctrl_off (.clk, .rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata(prdataOff), .pready(), .pslverr(), .portIn, .portOut(), .portOe(), .wired_or_irq_pin,
        .canAsleep, .wiredOrIrq(reqOff), .extClockOption(), .eeControl(), .irq());
    task chk(input logic [31:0] seen, input logic [31:0] want);
        n_checks++;
        if (seen !== want) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Look mid-cycle, where the answer has settled; it stands until the closing edge
        do begin
            @(negedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) err_count++;
        rd = prdata;
        rdOff = prdataOff;
        errS = pslverr;
        @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task results;
        $display("checks=%0d mismatches=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : results
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        results();
    end
    initial begin
        void'($urandom(32'hA284D571));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, ADDR_DIR_BASE + 8'h04, 32'h0);
        chk(rd, 32'h0);
        chk({8'h00, portOe}, 32'h0);
        $display("test reset done");
        // Output pins of port B drive high so a wrongly counted output shows up
        apb(1'b1, ADDR_DATA_BASE + 8'h04, 32'h000000FF);
        for (int i = 0; i < 24; i++) begin
            en = $urandom % 2;
            dir = $urandom % 256;
            ext = $urandom % 32'h1000000;
            cs = $urandom % 2;
            apb(1'b1, ADDR_CTRL, en << 7);
            apb(1'b1, ADDR_DIR_BASE + 8'h04, dir);
            drive <= ext[23:0];
            pinReq <= ($urandom % 4 == 0);
            canAsleep <= cs[0];
            repeat (4) @(posedge clk);
            expv = en & (pinReq | (((ext >> 8) & ~dir & 255) != 0));
            chk({31'h0, wiredOrIrq}, expv);
            chk({31'h0, reqOff}, 32'h0);
            apb(1'b0, ADDR_CTRL, 32'h0);
            chk(rd, (en << 7) | (cs << 6));
            chk(rdOff, cs << 6);
        end
        $display("test request done");
        pinReq <= 1'b0;
        drive <= 24'h0;
        apb(1'b1, ADDR_CTRL, 32'h80);
        apb(1'b1, ADDR_IRQ_STATUS, 32'h7);
        apb(1'b1, ADDR_IRQ_MASK, 32'h1);
        pinReq <= 1'b1;
        repeat (6) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, ADDR_IRQ_STATUS, 32'h1);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, ADDR_IRQ_MASK, 32'h0);
        pinReq <= 1'b0;
        repeat (4) @(posedge clk);
        pinReq <= 1'b1;
        repeat (6) @(posedge clk);
        apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
        chk({rd[0], irq}, 2'b10);
        apb(1'b0, 8'h30, 32'h0);
        chk({31'h0, errS}, 32'h1);
        apb(1'b1, 8'h1D, 32'h0);
        chk({31'h0, errS}, 32'h1);
        $display("test interrupt done");
        results();
    end
endmodule : wor_irq_ctrl_tb_top
